//--- core/access_port_pkg.sv
`default_nettype none
package access_port_pkg;

  // register offsets within the port's 8-bit register space
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_XFER_ADDR = 8'h04;
  localparam logic [7:0] OFS_DATA_RW   = 8'h0C;
  localparam logic [7:0] OFS_CONFIG    = 8'hF4;
  localparam logic [7:0] OFS_BASE      = 8'hF8;
  localparam logic [7:0] OFS_IDENT     = 8'hFC;

  // bank holding the four banked data windows
  localparam logic [3:0] BANKED_BANK   = 4'h1;

  // control register fields
  localparam int CTRL_ENABLE_BIT       = 0;
  localparam int CTRL_ERROR_BIT        = 8;

  // reset values
  localparam logic [31:0] RST_CONTROL   = 32'h0000_0001;
  localparam logic [31:0] RST_XFER_ADDR = 32'h0000_0000;
  localparam logic [31:0] RST_RDATA     = 32'h0000_0000;

  // debug components sit in whole blocks of this many address bits
  localparam int BLOCK_ADDR_BITS        = 12;
  localparam int BASE_PRESENT_BIT       = 0;

  typedef enum logic [1:0] {
    CLS_RESERVED = 2'b00,
    CLS_LOCAL    = 2'b01,
    CLS_MEMORY   = 2'b10
  } reg_class_e;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_WAIT = 1'b1
  } seq_state_e;

  typedef struct packed {
    logic [7:0]  port_select;
    logic [3:0]  bank_select;
    logic [1:0]  reg_index;
    logic        transfer_direction_bit; // 1 = read
    logic [31:0] wdata;
  } txn_s;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [31:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic [31:0] rdata;
    logic        error;
  } rsp_s;

endpackage
`default_nettype wire

//--- core/port_reg_decode.sv
`timescale 1ns/1ps
`default_nettype none
module port_reg_decode #(
  parameter logic [7:0] PORT_NUM = 8'h00
) (
  input  wire access_port_pkg::txn_s       txn,        // incoming transaction
  input  wire logic [31:0]                 xfer_addr,  // transfer address register
  output logic                             selected,   // this port is addressed
  output logic [7:0]                       offset,     // register offset
  output access_port_pkg::reg_class_e      reg_class,  // local, memory or reserved
  output logic [31:0]                      mem_addr    // downstream address
);

  wire is_data_rw = (offset == access_port_pkg::OFS_DATA_RW);
  wire is_banked  = (txn.bank_select == access_port_pkg::BANKED_BANK);
  wire is_local   = (offset == access_port_pkg::OFS_CONTROL)
                  | (offset == access_port_pkg::OFS_XFER_ADDR)
                  | (offset == access_port_pkg::OFS_CONFIG)
                  | (offset == access_port_pkg::OFS_BASE)
                  | (offset == access_port_pkg::OFS_IDENT);

  assign selected  = (txn.port_select == PORT_NUM); // [RULE2]
  assign offset    = {txn.bank_select, txn.reg_index, 2'b00}; // [RULE3] [RULE4] [RULE13]
  assign reg_class = is_local ? access_port_pkg::CLS_LOCAL :
                     (is_data_rw | is_banked) ? access_port_pkg::CLS_MEMORY :
                     access_port_pkg::CLS_RESERVED;
  // banked windows cover the aligned four words at the transfer address
  assign mem_addr  = is_banked ? {xfer_addr[31:4], txn.reg_index, 2'b00} : xfer_addr; // [RULE4]

endmodule // port_reg_decode
`default_nettype wire

//--- core/downstream_seq.sv
`timescale 1ns/1ps
`default_nettype none
module downstream_seq (
  input  wire logic                        core_clk,      // clock
  input  wire logic                        rstn,          // sync reset, active low
  input  wire logic                        start,         // launch one access
  input  wire access_port_pkg::mem_req_s   start_req,     // access to launch
  output logic                             busy,          // access outstanding
  output logic                             done,          // completion pulse
  output logic                             mem_req_valid, // downstream request
  output access_port_pkg::mem_req_s        mem_req,       // downstream address/data
  input  wire logic                        mem_done       // downstream completion
);

  access_port_pkg::seq_state_e state_reg, state_next;
  access_port_pkg::mem_req_s   req_reg;

  assign done          = (state_reg == access_port_pkg::SEQ_WAIT) & mem_done;
  assign busy          = (state_reg == access_port_pkg::SEQ_WAIT);
  assign mem_req_valid = busy;
  assign mem_req       = req_reg;

  // waits for completion however long it takes
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      access_port_pkg::SEQ_IDLE: if (start) state_next = access_port_pkg::SEQ_WAIT;
      access_port_pkg::SEQ_WAIT: if (mem_done) state_next = access_port_pkg::SEQ_IDLE; // [RULE6]
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_reg <= access_port_pkg::SEQ_IDLE;
      req_reg   <= '0;
    end else begin
      state_reg <= state_next;
      if (start && !busy) req_reg <= start_req;
    end
  end

endmodule // downstream_seq
`default_nettype wire

//--- core/access_port_select_decode.sv
// Function
// RULE1 - identification register readable at offset FC
// RULE2 - only the selected port takes transactions
// RULE3 - bank select forms offset bits 7:4
// RULE4 - register index picks one of four
// RULE5 - direction bit chooses read or write
// RULE6 - transaction may stall until downstream completes
// RULE7 - debugger skips port types it doesn't know
// RULE8 - local register access makes no downstream access
// RULE9 - components occupy whole 4KB address blocks
// RULE10 - several components require a 4KB identification table
// RULE11 - accepts transactions from either debug port variant
// RULE12 - local register transactions complete without stalling; here they wait while a downstream access is outstanding (txn_ready low)
// RULE13 - offset is bank, index, two zero bits
`timescale 1ns/1ps
`default_nettype none
module access_port_select_decode #(
  parameter logic [7:0]  PORT_NUM       = 8'h00,          // this port's select value
  parameter logic [31:0] IDENT_VALUE    = 32'h0A5A_0001,  // arbitrary identification value
  parameter logic [31:0] CONFIG_VALUE   = 32'h0000_0000,  // configuration word
  parameter logic [31:0] BASE_ADDR      = 32'h0000_0000,  // first component block
  parameter int          NUM_COMPONENTS = 1,              // debug components downstream
  parameter bit          TABLE_PRESENT  = 1'b0            // table fitted with one component
) (
  input  wire logic                       core_clk,      // clock
  input  wire logic                       rstn,          // sync reset, active low
  input  wire logic                       txn_valid,     // transaction offered
  input  wire access_port_pkg::txn_s      txn,           // selection, index, direction, data
  output logic                            txn_ready,     // transaction taken by this port
  output logic                            rsp_valid,     // answer pulse
  output access_port_pkg::rsp_s           rsp,           // read data and error
  output logic                            mem_req_valid, // downstream request held
  output access_port_pkg::mem_req_s       mem_req,       // downstream address/data
  input  wire logic                       mem_done,      // downstream completion
  input  wire logic [31:0]                mem_rdata,     // downstream read data
  input  wire logic                       mem_error      // downstream error
);

  logic                        selected;
  logic [7:0]                  offset;
  access_port_pkg::reg_class_e reg_class;
  logic [31:0]                 dec_mem_addr;
  logic                        seq_busy;
  logic                        seq_done;
  logic [31:0]                 control_reg;
  logic [31:0]                 xfer_addr_reg;
  logic                        rsp_valid_reg;
  logic                        rsp_valid_next;
  access_port_pkg::rsp_s       rsp_reg;
  access_port_pkg::rsp_s       rsp_next;
  logic                        pend_read_reg;
  logic [31:0]                 read_mux;
  access_port_pkg::mem_req_s   start_req;

  // one decode serves any debug port variant using the common selection
  port_reg_decode #(
    .PORT_NUM (PORT_NUM)
  ) u_decode (
    .txn       (txn),
    .xfer_addr (xfer_addr_reg),
    .selected  (selected),
    .offset    (offset),
    .reg_class (reg_class),
    .mem_addr  (dec_mem_addr)
  ); // [RULE11]

  wire taken       = txn_valid & txn_ready;
  wire is_read     = txn.transfer_direction_bit;
  wire is_write    = ~txn.transfer_direction_bit; // [RULE5]
  wire down_enable = control_reg[access_port_pkg::CTRL_ENABLE_BIT];
  wire take_local  = taken & (reg_class != access_port_pkg::CLS_MEMORY);
  wire take_mem    = taken & (reg_class == access_port_pkg::CLS_MEMORY);
  wire launch      = take_mem & down_enable;
  wire refuse_mem  = take_mem & ~down_enable;
  wire wr_control  = take_local & is_write & (offset == access_port_pkg::OFS_CONTROL);
  wire wr_xfer     = take_local & is_write & (offset == access_port_pkg::OFS_XFER_ADDR);
  wire err_event   = seq_done & mem_error;

  // base points at a whole block; the present bit flags the table
  wire        table_needed = (NUM_COMPONENTS > 1) | TABLE_PRESENT; // [RULE10]
  wire [31:0] base_word    = {BASE_ADDR[31:access_port_pkg::BLOCK_ADDR_BITS],
                              11'h000, table_needed}; // [RULE9]

  // unselected ports never claim; memory access blocks further requests
  assign txn_ready = selected & ~seq_busy; // [RULE2] [RULE6]
  assign start_req = '{addr: dec_mem_addr, write: is_write, wdata: txn.wdata}; // [RULE5]

  downstream_seq u_seq (
    .core_clk      (core_clk),
    .rstn          (rstn),
    .start         (launch),
    .start_req     (start_req),
    .busy          (seq_busy),
    .done          (seq_done),
    .mem_req_valid (mem_req_valid),
    .mem_req       (mem_req),
    .mem_done      (mem_done)
  ); // [RULE8]

  // local read data; reserved offsets read as zero
  always_comb begin
    unique case (offset)
      access_port_pkg::OFS_CONTROL:   read_mux = control_reg;
      access_port_pkg::OFS_XFER_ADDR: read_mux = xfer_addr_reg;
      access_port_pkg::OFS_CONFIG:    read_mux = CONFIG_VALUE;
      access_port_pkg::OFS_BASE:      read_mux = base_word;
      access_port_pkg::OFS_IDENT:     read_mux = IDENT_VALUE; // [RULE1]
      default:                        read_mux = 32'h0000_0000;
    endcase
  end

  // answer for local, refused and completed downstream accesses
  always_comb begin
    rsp_valid_next = 1'b0;
    rsp_next       = '{rdata: access_port_pkg::RST_RDATA, error: 1'b0};
    if (take_local) begin
      rsp_valid_next = 1'b1; // [RULE12]
      rsp_next.rdata = is_read ? read_mux : access_port_pkg::RST_RDATA;
    end else if (refuse_mem) begin
      rsp_valid_next = 1'b1;
      rsp_next.error = 1'b1;
    end else if (seq_done) begin
      rsp_valid_next = 1'b1;
      rsp_next.rdata = pend_read_reg ? mem_rdata : access_port_pkg::RST_RDATA;
      rsp_next.error = mem_error;
    end
  end

  assign rsp_valid = rsp_valid_reg;
  assign rsp       = rsp_reg;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rsp_valid_reg <= 1'b0;
      rsp_reg       <= '0;
      pend_read_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= rsp_valid_next;
      rsp_reg       <= rsp_next;
      if (launch) pend_read_reg <= is_read;
    end
  end

  // control: enable is writable, error flag is write-one-to-clear
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      control_reg <= access_port_pkg::RST_CONTROL;
    end else begin
      if (wr_control) begin
        control_reg[access_port_pkg::CTRL_ENABLE_BIT] <=
          txn.wdata[access_port_pkg::CTRL_ENABLE_BIT];
        if (txn.wdata[access_port_pkg::CTRL_ERROR_BIT])
          control_reg[access_port_pkg::CTRL_ERROR_BIT] <= 1'b0;
      end
      // a new error beats a clear in the same cycle
      if (err_event) control_reg[access_port_pkg::CTRL_ERROR_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      xfer_addr_reg <= access_port_pkg::RST_XFER_ADDR;
    end else if (wr_xfer) begin
      xfer_addr_reg <= txn.wdata;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence ident_read_taken;
    taken && is_read && txn.bank_select == 4'hF && txn.reg_index == 2'h3;
  endsequence

  sequence local_answer;
    rsp_valid && !mem_req_valid;
  endsequence

  sequence mem_launch;
    launch;
  endsequence

  chk_ident_read: assert property ( // [RULE1]
    ident_read_taken |=> rsp_valid && rsp.rdata == IDENT_VALUE && !rsp.error)
    else $error("identification read returned wrong value");

  chk_unselected_ignored: assert property ( // [RULE2]
    txn_valid && txn.port_select != PORT_NUM |-> !txn_ready)
    else $error("unselected port claimed a transaction");

  chk_bank_offset: assert property ( // [RULE3] [RULE13]
    taken && txn.bank_select == 4'hF && txn.reg_index == 2'h3
      |-> reg_class == access_port_pkg::CLS_LOCAL && read_mux == IDENT_VALUE)
    else $error("bank fifteen index three not decoded as identification");

  chk_banked_index: assert property ( // [RULE4]
    mem_launch ##0 (txn.bank_select == 4'h1)
      |=> mem_req_valid && mem_req.addr[3:2] == $past(txn.reg_index)
          && mem_req.addr[31:4] == $past(xfer_addr_reg[31:4]))
    else $error("banked window address does not follow index");

  chk_direction_bit: assert property ( // [RULE5]
    mem_launch |=> mem_req_valid && mem_req.write == !$past(txn.transfer_direction_bit))
    else $error("downstream direction differs from transaction");

  chk_stall_hold: assert property ( // [RULE6]
    mem_req_valid && !mem_done
      |=> mem_req_valid && !txn_ready && $stable(mem_req) && !rsp_valid)
    else $error("pending access dropped or answered early");

  chk_stall_answer: assert property ( // [RULE6]
    mem_req_valid && mem_done
      |=> rsp_valid && !mem_req_valid ##1 (!rsp_valid || $past(taken)))
    else $error("completed downstream access not answered once");

  chk_local_no_mem: assert property ( // [RULE8] [RULE12]
    take_local && !mem_req_valid |=> local_answer)
    else $error("local register access stalled or went downstream");

  chk_block_align: assert property ( // [RULE9]
    taken && is_read && offset == access_port_pkg::OFS_BASE
      |=> rsp.rdata[31:access_port_pkg::BLOCK_ADDR_BITS]
          == BASE_ADDR[31:access_port_pkg::BLOCK_ADDR_BITS]
          && rsp.rdata[access_port_pkg::BLOCK_ADDR_BITS-1:1] == '0)
    else $error("component base not on a whole block");

  chk_table_present: assert property ( // [RULE10]
    taken && is_read && offset == access_port_pkg::OFS_BASE && NUM_COMPONENTS > 1
      |=> rsp.rdata[access_port_pkg::BASE_PRESENT_BIT])
    else $error("identification table missing with several components");

  chk_err_set_wins: assert property (
    err_event |=> control_reg[access_port_pkg::CTRL_ERROR_BIT])
    else $error("error event lost to a clear");

  chk_disabled_refused: assert property (
    take_mem && !down_enable |=> rsp_valid && rsp.error && !mem_req_valid)
    else $error("disabled downstream access not refused");

  sequence local_take;
    take_local;
  endsequence

  chk_local_error_free: assert property ( // [RULE12]
    local_take |=> rsp_valid && !rsp.error)
    else $error("local register access answered with error");

  chk_write_answer_zero: assert property ( // [RULE5]
    local_take ##0 is_write |=> rsp_valid && rsp.rdata == 32'h0000_0000 && !rsp.error)
    else $error("local write answer not empty");

  chk_xfer_write: assert property ( // [RULE4]
    wr_xfer |=> xfer_addr_reg == $past(txn.wdata))
    else $error("transfer address write lost");

  chk_control_read: assert property ( // [RULE4]
    local_take ##0 (is_read && offset == access_port_pkg::OFS_CONTROL)
      |=> rsp.rdata == $past(control_reg))
    else $error("control read returned wrong value");

  chk_config_read: assert property ( // [RULE3]
    local_take ##0 (is_read && offset == access_port_pkg::OFS_CONFIG)
      |=> rsp.rdata == CONFIG_VALUE)
    else $error("configuration read returned wrong value");

  chk_reserved_zero: assert property ( // [RULE4]
    local_take ##0 (is_read && reg_class == access_port_pkg::CLS_RESERVED)
      |=> rsp_valid && rsp.rdata == 32'h0000_0000)
    else $error("reserved offset did not read as zero");

  chk_ready_select: assert property ( // [RULE2] [RULE11]
    !mem_req_valid && txn.port_select == PORT_NUM |-> txn_ready)
    else $error("selected idle port did not accept");

  chk_no_spurious_rsp: assert property ( // [RULE6]
    rsp_valid |-> $past(take_local || refuse_mem || seq_done))
    else $error("answer without a transaction");

  chk_mem_read_data: assert property ( // [RULE6]
    seq_done && pend_read_reg
      |=> rsp_valid && rsp.rdata == $past(mem_rdata) && rsp.error == $past(mem_error))
    else $error("downstream read data not returned");

  chk_mem_write_zero: assert property ( // [RULE5]
    seq_done && !pend_read_reg |=> rsp_valid && rsp.rdata == 32'h0000_0000)
    else $error("downstream write answer not empty");

  chk_req_launched: assert property ( // [RULE8]
    $rose(mem_req_valid) |-> $past(launch))
    else $error("downstream request without a memory transaction");

  chk_err_clear: assert property (
    wr_control && txn.wdata[access_port_pkg::CTRL_ERROR_BIT] && !err_event
      |=> !control_reg[access_port_pkg::CTRL_ERROR_BIT])
    else $error("error flag not cleared by write of one");

  chk_enable_write: assert property (
    wr_control |=> control_reg[access_port_pkg::CTRL_ENABLE_BIT]
      == $past(txn.wdata[access_port_pkg::CTRL_ENABLE_BIT]))
    else $error("downstream enable not written");

  chk_ready_after_answer: assert property ( // [RULE6]
    seq_done |=> !mem_req_valid && txn_ready == (txn.port_select == PORT_NUM))
    else $error("port not ready after downstream completion");

endmodule // access_port_select_decode
`default_nettype wire

//--- verification/mem_responder.sv
`timescale 1ns/1ps
`default_nettype none
module mem_responder (
  input  wire logic                      core_clk,      // clock
  input  wire logic                      rstn,          // sync reset, active low
  input  wire logic                      mem_req_valid, // request held
  input  wire access_port_pkg::mem_req_s mem_req,       // address and data
  input  wire logic [7:0]                delay,         // wait cycles before done
  input  wire logic                      err_mode,      // answer with error
  output logic                           mem_done,      // completion pulse
  output logic [31:0]                    mem_rdata,     // read data
  output logic                           mem_error      // error flag
);
  logic [7:0] wait_reg;

  // data and error change every cycle outside the done pulse
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wait_reg  <= 8'h00;
      mem_done  <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      mem_error <= 1'b0;
    end else if (mem_req_valid && !mem_done && wait_reg == delay) begin
      mem_done  <= 1'b1;
      mem_rdata <= mem_req.addr ^ 32'hA5A5_5A5A;
      mem_error <= err_mode;
      wait_reg  <= 8'h00;
    end else begin
      mem_done  <= 1'b0;
      mem_rdata <= ~mem_rdata;
      mem_error <= ~mem_error;
      if (mem_req_valid && !mem_done) wait_reg <= wait_reg + 8'h01;
    end
  end
endmodule // mem_responder
`default_nettype wire

//--- verification/access_port_select_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
module access_port_select_decode_tb;
  localparam logic [7:0]  port_num = 8'h03;
  localparam logic [31:0] ident    = 32'h1357_2468; // arbitrary value
  localparam logic [31:0] cfg      = 32'h0000_0001;
  localparam logic [31:0] base     = 32'h0004_2000;
  localparam logic [31:0] xa       = 32'h0000_3124;
  localparam logic [31:0] key      = 32'hA5A5_5A5A;

  logic                       core_clk;
  logic                       rstn;
  logic                       txn_valid;
  access_port_pkg::txn_s      txn;
  logic                       txn_ready;
  logic                       rsp_valid;
  access_port_pkg::rsp_s      rsp;
  logic                       mem_req_valid;
  access_port_pkg::mem_req_s  mem_req;
  logic                       mem_done;
  logic [31:0]                mem_rdata;
  logic                       mem_error;
  logic [7:0]                 delay;
  logic                       err_mode;
  access_port_pkg::rsp_s      got;
  access_port_pkg::mem_req_s  seen;
  logic                       saw_mem;
  int                         lat;
  int                         fail_count;
  int                         n_compared;
  int                         cycles;

  access_port_select_decode #(.PORT_NUM(port_num), .IDENT_VALUE(ident), .CONFIG_VALUE(cfg),
    .BASE_ADDR(base), .NUM_COMPONENTS(2), .TABLE_PRESENT(1'b0)) dut (
    .core_clk(core_clk), .rstn(rstn), .txn_valid(txn_valid), .txn(txn),
    .txn_ready(txn_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .mem_req_valid(mem_req_valid), .mem_req(mem_req), .mem_done(mem_done),
    .mem_rdata(mem_rdata), .mem_error(mem_error));

  mem_responder far_side (
    .core_clk(core_clk), .rstn(rstn), .mem_req_valid(mem_req_valid), .mem_req(mem_req),
    .delay(delay), .err_mode(err_mode), .mem_done(mem_done), .mem_rdata(mem_rdata),
    .mem_error(mem_error));

`define CHK(name, exp, val) \
  begin \
    n_compared++; \
    if ((val) !== (exp)) begin \
      fail_count++; \
      $display("unexpected %s: expected %h seen %h", name, exp, val); \
    end \
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one transaction; an unselected port must leave it untaken
  task automatic xact(input logic [7:0] port, input logic [3:0] bank, input logic [1:0] idx,
                      input logic rd, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    txn_valid <= 1'b1;
    txn <= '{port, bank, idx, rd, wd};
    #1;
    while (txn_ready !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (port != port_num) begin
      `CHK("txn_ready", 1'b0, txn_ready)
      `CHK("rsp_valid", 1'b0, rsp_valid)
      @(posedge core_clk);
      txn_valid <= 1'b0;
      return;
    end
    @(posedge core_clk);
    txn_valid <= 1'b0;
    lat = 0;
    saw_mem = 1'b0;
    #1;
    while (rsp_valid !== 1'b1 && lat < 200) begin
      if (mem_req_valid === 1'b1 && !saw_mem) begin
        saw_mem = 1'b1;
        seen = mem_req;
      end
      @(posedge core_clk);
      #1;
      lat++;
    end
    `CHK("rsp_valid", 1'b1, rsp_valid)
    got = rsp;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    cycles = 0;
    forever begin
      @(posedge core_clk);
      cycles++;
      if (cycles == 3000) begin
        fail_count++;
        complete_run();
      end
    end
  end

  initial begin
    rstn = 1'b0;
    txn_valid = 1'b0;
    txn = '0;
    delay = 8'h00;
    err_mode = 1'b0;
    fail_count = 0;
    n_compared = 0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    xact(port_num, 4'hF, 2'h3, 1'b1, 32'h0000_0000);
    `CHK("ident", ident, got.rdata)
    `CHK("ident latency", 0, lat)
    `CHK("ident downstream", 1'b0, saw_mem)
    xact(8'h05, 4'hF, 2'h3, 1'b1, 32'h0000_0000);
    xact(port_num, 4'h0, 2'h0, 1'b1, 32'h0000_0000);
    `CHK("control", access_port_pkg::RST_CONTROL, got.rdata)
    xact(port_num, 4'h0, 2'h1, 1'b0, xa);
    `CHK("address write", 32'h0000_0000, got.rdata)
    xact(port_num, 4'h0, 2'h1, 1'b1, 32'h0000_0000);
    `CHK("address", xa, got.rdata)
    xact(port_num, 4'hF, 2'h1, 1'b1, 32'h0000_0000);
    `CHK("config", cfg, got.rdata)
    xact(port_num, 4'hF, 2'h2, 1'b1, 32'h0000_0000);
    `CHK("base", {base[31:12], 11'h000, 1'b1}, got.rdata)
    xact(port_num, 4'h2, 2'h0, 1'b0, 32'h0000_FFFF);
    xact(port_num, 4'h2, 2'h0, 1'b1, 32'h0000_0000);
    `CHK("reserved", 32'h0000_0000, got.rdata)
    xact(port_num, 4'hF, 2'h3, 1'b0, 32'h0000_FFFF);
    xact(port_num, 4'hF, 2'h3, 1'b1, 32'h0000_0000);
    `CHK("ident after write", ident, got.rdata)
    delay = 8'h06;
    xact(port_num, 4'h0, 2'h3, 1'b1, 32'h0000_0000);
    `CHK("read addr", xa, seen.addr)
    `CHK("read dir", 1'b0, seen.write)
    `CHK("read data", xa ^ key, got.rdata)
    `CHK("read stalled", 1'b1, lat > 6)
    xact(port_num, 4'h0, 2'h3, 1'b0, 32'h0BAD_CAFE);
    `CHK("write dir", 1'b1, seen.write)
    `CHK("write data", 32'h0BAD_CAFE, seen.wdata)
    `CHK("write rsp", 32'h0000_0000, got.rdata)
    delay = 8'h00;
    for (int i = 0; i < 4; i++) begin
      xact(port_num, 4'h1, i[1:0], 1'b1, 32'h0000_0000);
      `CHK("banked addr", {xa[31:4], i[1:0], 2'b00}, seen.addr)
      `CHK("banked data", {xa[31:4], i[1:0], 2'b00} ^ key, got.rdata)
    end
    err_mode = 1'b1;
    xact(port_num, 4'h0, 2'h3, 1'b1, 32'h0000_0000);
    `CHK("mem error", 1'b1, got.error)
    err_mode = 1'b0;
    xact(port_num, 4'h0, 2'h0, 1'b1, 32'h0000_0000);
    `CHK("control sticky", 32'h0000_0101, got.rdata)
    xact(port_num, 4'h0, 2'h0, 1'b0, 32'h0000_0100);
    xact(port_num, 4'h0, 2'h0, 1'b1, 32'h0000_0000);
    `CHK("control cleared", 32'h0000_0000, got.rdata)
    xact(port_num, 4'h0, 2'h3, 1'b1, 32'h0000_0000);
    `CHK("disabled error", 1'b1, got.error)
    `CHK("disabled downstream", 1'b0, saw_mem)
    `CHK("disabled latency", 0, lat)
    complete_run();
  end
endmodule // access_port_select_decode_tb
`default_nettype wire
